// ---- shared/sdc_pkg.sv ----
// Package of constants, types and command encodings for the SDRAM command block
// Operation
// - Read or write with address bit 10 high closes the bank after the burst; in full page mode the command is refused instead.
// - Read auto-precharge starts a latency-set number of clocks before burst end.
// - Write auto-precharge starts precharge two clocks after last write data.
// - Precharge decode; bit 10 low closes selected bank, high closes all banks.
// - Self refresh entered on select, row, column and clock enable low, write high.
// - In self refresh only clock enable is heeded; clock enable high exits.
// - No-operation decode never ends a burst in progress.
// - Chip select high is deselect, equal to no-operation; strobes ignored.
// - Clock enable low with a bank active enters clock suspend one clock later.
// - Clock suspend ends one clock after clock enable is sampled high.
// - With previous clock enable high, strobes decode the full command table.
// - Clock enable falling in a burst gives clock suspend, not power down.
package sdc_pkg;

  localparam int NBANK = 4;
  localparam int BL_W = 4;
  // Write recovery in clocks
  localparam logic [3:0] WR_CLKS = 4'h2;
  // Clocks a full page burst is taken to last
  localparam logic [8:0] FULL_PAGE_LEN = 9'h100;
  // Reset values of the programmed mode, and the full page burst length code
  localparam logic [2:0] RST_CAS_LAT = 3'h2;
  localparam logic [2:0] RST_BL_CODE = 3'h0;
  localparam logic [2:0] BL_CODE_FULL = 3'h7;

  // Command codes (select, row, column, write enable)
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_NOP = 4'h7;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ACT = 4'h1,
    OP_RD = 4'h2,
    OP_WR = 4'h3,
    OP_MRS = 4'h4,
    OP_REF = 4'h5,
    OP_BST = 4'h6,
    OP_PRE = 4'h7,
    OP_PREALL = 4'h8,
    OP_SREF = 4'h9
  } sdc_op_t;

  // Pin group sampled each edge
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank;
    logic [10:0] addr;
  } sdc_pins_t;

  // Decoded command
  typedef struct packed {
    sdc_op_t op;
    logic [1:0] bank;
    logic autopre;
  } sdc_cmd_t;

  // Power modes, Gray along normal -> suspend -> power down -> self refresh
  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_SUSPEND = 2'b01,
    PM_PDOWN = 2'b11,
    PM_SREF = 2'b10
  } sdc_pm_t;

endpackage

// ---- hw/sdc_decode.sv ----
// Command decoder for the SDRAM command pins
`timescale 1ns/1ns
module sdc_decode
  import sdc_pkg::*;
(
  input wire sdc_pins_t pins_i,
  input wire logic cke_prev_i,
  output sdc_cmd_t cmd_o
);

  wire [3:0] code = {pins_i.cs_n, pins_i.ras_n, pins_i.cas_n, pins_i.we_n};
  wire a10 = pins_i.addr[10];
  wire sel = ~pins_i.cs_n;
  wire sref_hit = cke_prev_i & ~pins_i.cke & (code == CMD_REF);

  // Table decode, only when previous clock enable was high
  always_comb begin
    cmd_o.op = OP_NONE;
    cmd_o.bank = pins_i.bank;
    cmd_o.autopre = 1'b0;
    if (cke_prev_i && sel) begin
      unique case (code)
        CMD_ACT: cmd_o.op = OP_ACT;
        CMD_RD: begin
          cmd_o.op = OP_RD;
          cmd_o.autopre = a10;
        end
        CMD_WR: begin
          cmd_o.op = OP_WR;
          cmd_o.autopre = a10;
        end
        CMD_MRS: cmd_o.op = OP_MRS;
        CMD_REF: cmd_o.op = sref_hit ? OP_SREF : (pins_i.cke ? OP_REF : OP_NONE);
        CMD_BST: cmd_o.op = OP_BST;
        CMD_PRE: cmd_o.op = a10 ? OP_PREALL : OP_PRE;
        CMD_NOP: cmd_o.op = OP_NONE;
        default: cmd_o.op = OP_NONE;
      endcase
    end
  end

endmodule // sdc_decode

// ---- hw/sdc_bank.sv ----
// State of one bank: open flag, burst countdown and auto-precharge timer
`timescale 1ns/1ns
module sdc_bank
  import sdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic run_i,
  input wire logic act_i,
  input wire logic close_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic stop_i,
  input wire logic autopre_i,
  input wire logic [8:0] blen_i,
  input wire logic [2:0] cas_lat_i,
  output logic open_o,
  output logic burst_o,
  output logic ap_busy_o
);

  logic open_r;
  logic [8:0] cnt_r;
  logic ap_r;
  logic wr_r;
  logic [3:0] rec_r;

  // Read precharge lead is latency minus one clocks before burst end
  wire [8:0] rd_lead = {6'h0, cas_lat_i} - 9'h1;
  wire last_beat = (cnt_r == 9'h1);
  wire rd_pre = ap_r & ~wr_r & (cnt_r != 9'h0) & (cnt_r <= rd_lead + 9'h1);
  wire wr_done = ap_r & wr_r & (rec_r == 4'h1);
  wire new_burst = rd_i | wr_i;

  assign open_o = open_r;
  assign burst_o = (cnt_r != 9'h0);
  assign ap_busy_o = ap_r;

  // Bank state, held while suspended
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      open_r <= 1'b0;
      cnt_r <= 9'h0;
      ap_r <= 1'b0;
      wr_r <= 1'b0;
      rec_r <= 4'h0;
    end else if (run_i) begin
      if (act_i) begin
        open_r <= 1'b1;
      end else if (close_i || rd_pre || wr_done) begin
        open_r <= 1'b0;
      end
      if (new_burst) begin
        cnt_r <= blen_i;
        ap_r <= autopre_i;
        wr_r <= wr_i;
        rec_r <= 4'h0;
      end else if (stop_i) begin
        cnt_r <= 9'h0;
      end else if (cnt_r != 9'h0) begin
        cnt_r <= cnt_r - 9'h1;
        if (last_beat && ap_r && wr_r) begin
          rec_r <= WR_CLKS;
        end
      end else if (rec_r != 4'h0) begin
        rec_r <= rec_r - 4'h1;
      end
      if (rd_pre || wr_done || close_i) begin
        ap_r <= 1'b0;
      end
    end
  end

endmodule // sdc_bank

// ---- hw/sdc_core.sv ----
// SDRAM command block: decode, bank tracking and power modes
`timescale 1ns/1ns
module sdc_core
  import sdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic bank_select_0_i,
  input wire logic bank_select_1_i,
  input wire logic [10:0] addr_i,
  output logic [NBANK-1:0] bank_open_o,
  output logic burst_o,
  output logic [1:0] pmode_o,
  output logic illegal_o,
  output logic [2:0] cas_lat_o,
  output logic [2:0] bl_code_o
);

  ////////////////////////////////////////////////////////////////
  // Pin sampling and decode
  sdc_pins_t pins;
  sdc_cmd_t cmd;
  logic cke_prev_r;
  sdc_pm_t pm_r;
  sdc_pm_t pm_nxt;
  logic [2:0] cas_lat_r;
  logic [2:0] bl_code_r;
  logic illegal_r;
  logic illegal_nxt;
  logic [NBANK-1:0] open_v;
  logic [NBANK-1:0] burst_v;
  logic [NBANK-1:0] apb_v;

  assign pins = '{cke: cke_i, cs_n: cs_n_i, ras_n: ras_n_i, cas_n: cas_n_i, we_n: we_n_i,
                  bank: {bank_select_1_i, bank_select_0_i}, addr: addr_i};

  sdc_decode u_dec (
    .pins_i(pins),
    .cke_prev_i(cke_prev_r),
    .cmd_o(cmd)
  );

  ////////////////////////////////////////////////////////////////
  // Mode-derived burst length
  logic [8:0] blen;
  always_comb begin
    unique case (bl_code_r)
      3'h0: blen = 9'h1;
      3'h1: blen = 9'h2;
      3'h2: blen = 9'h4;
      3'h3: blen = 9'h8;
      BL_CODE_FULL: blen = FULL_PAGE_LEN;
      default: blen = 9'h1;
    endcase
  end

  // Commands are taken only in normal mode
  wire running = (pm_r == PM_NORMAL);
  wire take = running & cke_prev_r;
  wire any_open = |open_v;
  wire any_burst = |burst_v;
  wire is_full = (bl_code_r == BL_CODE_FULL);
  wire ap_full = take & (cmd.op == OP_RD || cmd.op == OP_WR) & cmd.autopre & is_full;
  wire tgt_open = open_v[cmd.bank];
  wire tgt_apb = apb_v[cmd.bank];

  ////////////////////////////////////////////////////////////////
  // Per-bank state
  genvar g;
  generate
    for (g = 0; g < NBANK; g++) begin : g_bank
      wire hit = take & (cmd.bank == 2'(g));
      wire ok = ~apb_v[g];
      sdc_bank u_bank (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .run_i(running),
        .act_i(hit & (cmd.op == OP_ACT) & ~open_v[g]),
        .close_i((hit & (cmd.op == OP_PRE) & ok) | (take & (cmd.op == OP_PREALL))),
        .rd_i(hit & (cmd.op == OP_RD) & open_v[g] & ok & ~ap_full),
        .wr_i(hit & (cmd.op == OP_WR) & open_v[g] & ok & ~ap_full),
        .stop_i(take & (cmd.op == OP_BST) & is_full),
        .autopre_i(cmd.autopre),
        .blen_i(blen),
        .cas_lat_i(cas_lat_r),
        .open_o(open_v[g]),
        .burst_o(burst_v[g]),
        .ap_busy_o(apb_v[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Legality check of the decoded command against bank state
  always_comb begin
    illegal_nxt = 1'b0;
    if (take) begin
      unique case (cmd.op)
        OP_ACT: illegal_nxt = tgt_open;
        OP_RD, OP_WR: illegal_nxt = ~tgt_open | tgt_apb | ap_full;
        OP_PRE: illegal_nxt = tgt_apb;
        OP_MRS, OP_REF, OP_SREF: illegal_nxt = any_open;
        OP_BST: illegal_nxt = ~is_full;
        default: illegal_nxt = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Power mode sequencing
  always_comb begin
    pm_nxt = pm_r;
    unique case (pm_r)
      PM_NORMAL: begin
        if (take && cmd.op == OP_SREF && !any_open) begin
          pm_nxt = PM_SREF;
        end else if (!cke_i && (any_open || any_burst)) begin
          pm_nxt = PM_SUSPEND;
        end else if (!cke_i) begin
          pm_nxt = PM_PDOWN;
        end
      end
      PM_SUSPEND: if (cke_i) pm_nxt = PM_NORMAL;
      PM_PDOWN: if (cke_i) pm_nxt = PM_NORMAL;
      PM_SREF: if (cke_i) pm_nxt = PM_NORMAL;
    endcase
  end

  // Registered state
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cke_prev_r <= 1'b0;
      pm_r <= PM_NORMAL;
      cas_lat_r <= RST_CAS_LAT;
      bl_code_r <= RST_BL_CODE;
      illegal_r <= 1'b0;
    end else begin
      cke_prev_r <= cke_i;
      pm_r <= pm_nxt;
      illegal_r <= illegal_nxt;
      if (take && cmd.op == OP_MRS && !any_open) begin
        cas_lat_r <= addr_i[6:4];
        bl_code_r <= addr_i[2:0];
      end
    end
  end

  assign bank_open_o = open_v;
  assign burst_o = any_burst;
  assign pmode_o = pm_r;
  assign illegal_o = illegal_r;
  assign cas_lat_o = cas_lat_r;
  assign bl_code_o = bl_code_r;

endmodule // sdc_core

// ---- test/sdc_core_props.sv ----
// Concurrent checks on the ports of the SDRAM command block
`timescale 1ns/1ns
module sdc_core_props
  import sdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic bank_select_0_i,
  input wire logic bank_select_1_i,
  input wire logic [10:0] addr_i,
  input wire logic [NBANK-1:0] bank_open_o,
  input wire logic burst_o,
  input wire logic [1:0] pmode_o,
  input wire logic illegal_o,
  input wire logic [2:0] cas_lat_o,
  input wire logic [2:0] bl_code_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////
  // Previous clock enable and taken-command decode
  logic cke_q_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) cke_q_r <= 1'b0;
    else cke_q_r <= cke_i;
  end
  wire logic [3:0] cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  wire logic [1:0] bnk = {bank_select_1_i, bank_select_0_i};
  wire logic take = cke_q_r && pmode_o == PM_NORMAL && !cs_n_i;
  wire logic idle = bank_open_o == '0 && !burst_o;
  ////////////////////////////////////////////////////////////////
  AST_PRE_ONE: assert property (take && cmd == CMD_PRE && !addr_i[10] |=> !bank_open_o[$past(bnk)])
    else $error("single bank precharge left bank open");
  AST_PRE_ALL: assert property (take && cmd == CMD_PRE && addr_i[10] |=> bank_open_o == '0)
    else $error("precharge all left a bank open");
  AST_ACT: assert property (take && cmd == CMD_ACT && !bank_open_o[bnk] |=> bank_open_o[$past(bnk)])
    else $error("activate did not open bank");
  AST_SREF: assert property (take && cmd == CMD_REF && !cke_i && idle |=> pmode_o == PM_SREF)
    else $error("self refresh not entered");
  AST_SREF_HOLD: assert property (pmode_o == PM_SREF && !cke_i |=> pmode_o == PM_SREF)
    else $error("self refresh left with clock enable low");
  AST_SUSP: assert property (cke_q_r && pmode_o == PM_NORMAL && !cke_i && !idle |=> pmode_o == PM_SUSPEND)
    else $error("clock suspend not entered");
  AST_SUSP_EXIT: assert property (pmode_o == PM_SUSPEND && cke_i |=> pmode_o == PM_NORMAL)
    else $error("clock suspend not left");
  AST_NOP: assert property (cke_q_r && (cs_n_i || cmd == CMD_NOP)
    |=> !illegal_o && (bank_open_o & ~$past(bank_open_o)) == '0)
    else $error("no-operation or deselect acted");
  C_SREF: cover property (pmode_o == PM_SREF);
  C_SUSP: cover property (pmode_o == PM_SUSPEND);
  C_PDOWN: cover property (pmode_o == PM_PDOWN);
endmodule // sdc_core_props
bind sdc_core sdc_core_props u_props (.clk_i(clk_i), .resetn_i(resetn_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
  .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .bank_select_0_i(bank_select_0_i),
  .bank_select_1_i(bank_select_1_i), .addr_i(addr_i), .bank_open_o(bank_open_o), .burst_o(burst_o),
  .pmode_o(pmode_o), .illegal_o(illegal_o), .cas_lat_o(cas_lat_o), .bl_code_o(bl_code_o));

// ---- test/sdc_ctl_model.sv ----
// Memory controller model driving the SDRAM command pins
`timescale 1ns/1ns
module sdc_ctl_model
  import sdc_pkg::*;
(
  input wire logic clk_i,
  output sdc_pins_t pins_o
);
  // Idle is deselect with clock enable high
  initial begin
    pins_o = {1'b1, 4'hf, 2'h0, 11'h000};
  end
  // One command per clock, driven just after the edge and held a full cycle
  task automatic issue(input logic cke, input logic [3:0] cmd, input logic [1:0] bank, input logic [10:0] addr);
    @(posedge clk_i);
    #1;
    pins_o = {cke, cmd, bank, addr};
  endtask
endmodule // sdc_ctl_model

// ---- test/test_sdc_core.sv ----
// Self-checking bench for the SDRAM command block
`timescale 1ns/1ns
module test_sdc_core
  import sdc_pkg::*;
;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  sdc_pins_t p;
  logic [NBANK-1:0] bank_open_o;
  logic burst_o;
  logic [1:0] pmode_o;
  logic illegal_o;
  logic [2:0] cas_lat_o;
  logic [2:0] bl_code_o;
  // Refresh commands in one recommended burst around self refresh
  localparam int REF_BURST = 4096;
  int bad_count = 0;
  int tests_run = 0;
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  sdc_ctl_model ctl (.clk_i(clk_i), .pins_o(p));
  sdc_core DUT (.clk_i(clk_i), .resetn_i(resetn_i), .cke_i(p.cke), .cs_n_i(p.cs_n), .ras_n_i(p.ras_n),
    .cas_n_i(p.cas_n), .we_n_i(p.we_n), .bank_select_0_i(p.bank[0]), .bank_select_1_i(p.bank[1]),
    .addr_i(p.addr), .bank_open_o(bank_open_o), .burst_o(burst_o), .pmode_o(pmode_o),
    .illegal_o(illegal_o), .cas_lat_o(cas_lat_o), .bl_code_o(bl_code_o));
  ////////////////////////////////////////////////////////////////
  // Compare, issue shorthand and closing report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic cke, input logic [3:0] c, input logic [1:0] b, input logic [10:0] a);
    ctl.issue(cke, c, b, a);
  endtask
  task automatic nops(input int n);
    for (int i = 0; i < n; i++) cmd(1'b1, CMD_NOP, 2'h0, 11'h000);
  endtask
  task automatic refs(input int n);
    for (int i = 0; i < n; i++) cmd(1'b1, CMD_REF, 2'h0, 11'h000);
  endtask
  task automatic finish_test();
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk({cas_lat_o, bl_code_o, pmode_o}, 8'h40);
    chk({4'h0, bank_open_o}, 8'h00);
  endtask
  task automatic t_autopre();
    cmd(1'b1, CMD_ACT, 2'h1, 11'h000);
    cmd(1'b1, CMD_RD, 2'h1, 11'h400);
    nops(1);
    chk({3'h0, burst_o, bank_open_o}, 8'h12);
    nops(3);
    chk({4'h0, bank_open_o}, 8'h00);
    cmd(1'b1, CMD_ACT, 2'h1, 11'h000);
    cmd(1'b1, CMD_WR, 2'h1, 11'h400);
    nops(2);
    chk({4'h0, bank_open_o}, 8'h02);
    nops(3);
    chk({4'h0, bank_open_o}, 8'h00);
  endtask
  task automatic t_pre();
    nops(2);
    cmd(1'b1, CMD_ACT, 2'h0, 11'h000);
    cmd(1'b1, CMD_ACT, 2'h2, 11'h000);
    cmd(1'b1, CMD_PRE, 2'h0, 11'h000);
    nops(1);
    chk({4'h0, bank_open_o}, 8'h04);
    cmd(1'b1, CMD_PRE, 2'h0, 11'h400);
    cmd(1'b1, CMD_RD, 2'h3, 11'h000);
    nops(1);
    chk({3'h0, illegal_o, bank_open_o}, 8'h10);
  endtask
  task automatic t_table();
    cmd(1'b1, CMD_MRS, 2'h0, 11'h031);
    cmd(1'b1, 4'h8, 2'h0, 11'h020);
    cmd(1'b1, CMD_REF, 2'h0, 11'h000);
    chk({2'h0, cas_lat_o, bl_code_o}, 8'h19);
    cmd(1'b1, CMD_MRS, 2'h0, 11'h020);
    nops(1);
    chk({2'h0, cas_lat_o, bl_code_o}, 8'h10);
  endtask
  // Full page read stopped by burst stop, then burst stop refused at length one
  task automatic t_full();
    cmd(1'b1, CMD_MRS, 2'h0, 11'h027);
    cmd(1'b1, CMD_ACT, 2'h0, 11'h000);
    cmd(1'b1, CMD_RD, 2'h0, 11'h000);
    nops(1);
    chk({3'h0, burst_o, bank_open_o}, 8'h11);
    cmd(1'b1, CMD_BST, 2'h0, 11'h000);
    nops(1);
    chk({3'h0, burst_o, bank_open_o}, 8'h01);
    cmd(1'b1, CMD_PRE, 2'h0, 11'h000);
    cmd(1'b1, CMD_MRS, 2'h0, 11'h020);
    cmd(1'b1, CMD_BST, 2'h0, 11'h000);
    nops(1);
    chk({3'h0, illegal_o, bank_open_o}, 8'h10);
  endtask
  task automatic t_power();
    cmd(1'b1, CMD_ACT, 2'h3, 11'h000);
    cmd(1'b0, CMD_NOP, 2'h0, 11'h000);
    cmd(1'b0, CMD_PRE, 2'h3, 11'h400);
    chk({2'h0, pmode_o, bank_open_o}, 8'h18);
    cmd(1'b1, CMD_NOP, 2'h0, 11'h000);
    nops(1);
    chk({2'h0, pmode_o, bank_open_o}, 8'h08);
    cmd(1'b1, CMD_PRE, 2'h3, 11'h000);
    cmd(1'b0, 4'hf, 2'h0, 11'h000);
    nops(1);
    chk({6'h0, pmode_o}, 8'h03);
    nops(2);
    chk({6'h0, pmode_o}, 8'h00);
    refs(REF_BURST);
    cmd(1'b0, CMD_REF, 2'h0, 11'h000);
    cmd(1'b0, CMD_ACT, 2'h0, 11'h000);
    nops(1);
    chk({2'h0, pmode_o, bank_open_o}, 8'h20);
    nops(3);
    chk({2'h0, pmode_o, bank_open_o}, 8'h00);
    refs(REF_BURST);
    nops(1);
    chk({3'h0, illegal_o, bank_open_o}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence and hang guard
  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    t_reset();
    nops(3);
    t_autopre();
    t_pre();
    t_table();
    t_full();
    t_power();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    finish_test();
  end
endmodule // test_sdc_core
